// File: rtl/bcs_pkg.sv
// Shared constants and carrier types for the burst cache RAM control
package bcs_pkg;
  localparam int ADDR_W     = 16;
  localparam int LANE_W     = 9;
  localparam int WORD_W     = 18;
  localparam int CNT_W      = 2;
  localparam int ACCESS_PS  = 8500;
  localparam int CLK_PS     = 25000;
  // Access time floored to whole cycles, at least one
  localparam int ACCESS_CYC = (ACCESS_PS / CLK_PS) < 1 ? 1 : (ACCESS_PS / CLK_PS);
  localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;

  typedef enum logic {BCS_INTERLEAVED, BCS_LINEAR} bcs_order_t;
  typedef enum {BCS_IDLE, BCS_CPU_WAIT, BCS_BURST} bcs_state_t;

  // Control strobes sampled at each clock rise
  typedef struct packed {
    logic chip_sel_n;
    logic cpu_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_step_n;
    logic write_upper_lane_n;
    logic write_lower_lane_n;
  } bcs_ctrl_t;

  // One data lane: eight data bits plus its parity bit
  typedef struct packed {
    logic       par;
    logic [7:0] dat;
  } bcs_lane_t;
endpackage

// File: rtl/bcs_sram.sv
// Burst cache RAM: address strobes, self-timed lane writes, burst counter
module bcs_sram #(
  parameter bcs_pkg::bcs_order_t ORDER = bcs_pkg::BCS_INTERLEAVED,
  parameter int                  DEPTH = 65536
) (
  input  wire logic                          clk_sys,
  input  wire logic                          arst_n,
  input  wire bcs_pkg::bcs_ctrl_t            ctrl,
  input  wire logic                          out_enable_n,
  input  wire logic [bcs_pkg::ADDR_W-1:0]    addr,
  input  wire logic [bcs_pkg::WORD_W-1:0]    dq_in,
  output logic      [bcs_pkg::WORD_W-1:0]    dq_out,
  output logic      [bcs_pkg::WORD_W-1:0]    dq_oe
);

  // Number of byte lanes in one word
  localparam int LANES = bcs_pkg::WORD_W / bcs_pkg::LANE_W;

  // Refuse a depth the address cannot reach
  if (DEPTH != (1 << bcs_pkg::ADDR_W)) begin : g_bad_depth
    $error("DEPTH must equal 2**ADDR_W");
  end

  // Refuse a word that is not two whole lanes
  if ((LANES != 2) || (LANES * bcs_pkg::LANE_W != bcs_pkg::WORD_W)) begin : g_bad_lanes
    $error("WORD_W must hold exactly two lanes of LANE_W");
  end

  // Address register, burst counter and state
  logic [bcs_pkg::ADDR_W-1:0]   base_q;
  logic [bcs_pkg::CNT_W-1:0]    start_q;
  logic [bcs_pkg::CNT_W-1:0]    step_q;
  logic [bcs_pkg::CNT_W-1:0]    step_d;
  bcs_pkg::bcs_state_t          state_q;
  bcs_pkg::bcs_state_t          state_d;

  // Read path registers and the addressed word
  logic [bcs_pkg::WORD_W-1:0]   rdata_q;
  logic [bcs_pkg::WORD_W-1:0]   rdata_d;
  logic                         rvalid_q;
  logic                         rvalid_d;
  logic [bcs_pkg::WORD_W-1:0]   rd_word;
  logic [bcs_pkg::WORD_W-1:0]   lane_float;

  // Sampled control levels, turned active high
  wire                sel      = ~ctrl.chip_sel_n;
  wire                cpu_req  = ~ctrl.cpu_addr_strobe_n;
  wire                ctl_req  = ~ctrl.ctrl_addr_strobe_n;
  wire                step_req = ~ctrl.burst_step_n;
  wire [LANES-1:0]    lane_raw = {~ctrl.write_upper_lane_n, ~ctrl.write_lower_lane_n};
  wire                any_lane = |lane_raw;
  wire                active   = (state_q != bcs_pkg::BCS_IDLE);

  // Strobe acceptance; processor strobe wins, deselect drops it
  wire cpu_go    = sel & cpu_req;
  wire ctl_go    = sel & ~cpu_req & ctl_req;
  wire load      = cpu_go | ctl_go;

  // Write qualification for controller strobes and for cycles after either strobe
  wire ctl_write    = ctl_go & any_lane;
  wire follow_write = sel & ~load & active & any_lane;
  wire do_write     = ctl_write | follow_write;

  // Lanes ignored in a processor load cycle, so tag checks can run
  wire [LANES-1:0] lane_en = cpu_go ? '0 : lane_raw;

  // Advance only inside a burst and never with a strobe
  wire stepping = ~load & step_req & active;
  wire [bcs_pkg::CNT_W-1:0] step_inc = step_q + bcs_pkg::CNT_ONE;

  // Low address bits for both burst orders
  wire [bcs_pkg::CNT_W-1:0] low_ilv_cur = start_q ^ step_q;
  wire [bcs_pkg::CNT_W-1:0] low_lin_cur = start_q + step_q;
  wire [bcs_pkg::CNT_W-1:0] low_ilv_nxt = start_q ^ step_inc;
  wire [bcs_pkg::CNT_W-1:0] low_lin_nxt = start_q + step_inc;

  // Order selection, fixed at build time
  wire                      is_ilv  = (ORDER == bcs_pkg::BCS_INTERLEAVED);
  wire [bcs_pkg::CNT_W-1:0] low_cur = is_ilv ? low_ilv_cur : low_lin_cur;
  wire [bcs_pkg::CNT_W-1:0] low_nxt = is_ilv ? low_ilv_nxt : low_lin_nxt;

  // Full burst addresses from the held upper bits
  wire [bcs_pkg::ADDR_W-bcs_pkg::CNT_W-1:0] base_hi =
    base_q[bcs_pkg::ADDR_W-1:bcs_pkg::CNT_W];
  wire [bcs_pkg::ADDR_W-1:0] cur_addr  = {base_hi, low_cur};
  wire [bcs_pkg::ADDR_W-1:0] next_addr = {base_hi, low_nxt};

  // Write goes to the pins on a controller write, else the counter
  wire [bcs_pkg::ADDR_W-1:0] wr_addr = ctl_write ? addr : cur_addr;

  // Read address: pins on a strobe, next word on a step
  wire [bcs_pkg::ADDR_W-1:0] rd_addr = load ? addr : (stepping ? next_addr : cur_addr);

  // Read starts, burst steps and holding of valid data
  wire rd_start = (load & ~any_lane) | cpu_go;
  wire rd_next  = stepping & ~any_lane;
  wire rd_load  = rd_start | rd_next;
  wire rd_keep  = rvalid_q & ~any_lane & ~load;

  // Read register next values
  assign rvalid_d = (rd_load | rd_keep) & sel;
  assign rdata_d  = rd_load ? rd_word : rdata_q;

  // Counter and state next values
  always_comb begin
    step_d  = step_q;
    state_d = state_q;
    case (state_q)
      bcs_pkg::BCS_IDLE: begin
        state_d = bcs_pkg::BCS_IDLE;
      end
      bcs_pkg::BCS_CPU_WAIT, bcs_pkg::BCS_BURST: begin
        if (stepping) begin
          step_d = step_inc;
        end
        state_d = bcs_pkg::BCS_BURST;
      end
      default: begin
        state_d = bcs_pkg::BCS_IDLE;
      end
    endcase
    if (load) begin
      step_d  = '0;
      state_d = cpu_go ? bcs_pkg::BCS_CPU_WAIT : bcs_pkg::BCS_BURST;
    end
  end

  // Address register, burst counter and state
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      base_q  <= '0;
      start_q <= '0;
      step_q  <= '0;
      state_q <= bcs_pkg::BCS_IDLE;
    end else begin
      if (load) begin
        base_q  <= addr;
        start_q <= addr[bcs_pkg::CNT_W-1:0];
      end
      step_q  <= step_d;
      state_q <= state_d;
    end
  end

  // Per-lane storage, self-timed write, read and float
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    // One lane of every word, data and parity alike
    logic [bcs_pkg::LANE_W-1:0] lane_mem [DEPTH];

    // Lane slice of the write data and its write strobe
    wire [bcs_pkg::LANE_W-1:0] lane_in = dq_in[g*bcs_pkg::LANE_W +: bcs_pkg::LANE_W];
    wire                       lane_wr = do_write & lane_en[g];

    // Lane slice of the addressed word and of the float mask
    assign rd_word[g*bcs_pkg::LANE_W +: bcs_pkg::LANE_W]    = lane_mem[rd_addr];
    assign lane_float[g*bcs_pkg::LANE_W +: bcs_pkg::LANE_W] = {bcs_pkg::LANE_W{lane_raw[g]}};

    // Write at the sampling edge
    always_ff @(posedge clk_sys) begin
      if (lane_wr) begin
        lane_mem[wr_addr] <= lane_in;
      end
    end
  end

  // Read data register, valid from the edge that samples the strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
    end
  end

  // Output drivers, enable from async OE and the live, unregistered lane write inputs
  assign dq_out = rdata_q;
  assign dq_oe  = {bcs_pkg::WORD_W{rvalid_q & ~out_enable_n}} & ~lane_float;

endmodule

// File: bench/bcs_sram_props.sv
// Port checker for the burst cache RAM
module bcs_sram_props (
  input wire logic               clk_sys,
  input wire logic               arst_n,
  input wire bcs_pkg::bcs_ctrl_t ctrl,
  input wire logic               out_enable_n,
  input wire logic [17:0]        dq_out,
  input wire logic [17:0]        dq_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Decoded strobe and lane state
  wire cs = ctrl.chip_sel_n, cp = ctrl.cpu_addr_strobe_n, wl = ctrl.write_lower_lane_n;
  wire wu = ctrl.write_upper_lane_n, idle = cp & ctrl.ctrl_addr_strobe_n, hi = wl & wu;
  a_lo_float: assert property (!wl && cp |-> dq_oe[8:0] == 9'h0) else $error("lo on");
  a_up_float: assert property (!wu && cp |-> dq_oe[17:9] == 9'h0) else $error("up on");
  a_oe_async: assert property (out_enable_n |-> dq_oe == 18'h0) else $error("oe");
  a_lo_whole: assert property (dq_oe[8:0] inside {9'h0, 9'h1ff}) else $error("lo");
  a_up_whole: assert property (dq_oe[17:9] inside {9'h0, 9'h1ff}) else $error("up");
  a_read_drive: assert property (
    !cs && !idle && hi |=> out_enable_n || !hi || !cp || cs || dq_oe == 18'h3ffff) else $error("rd");
  a_out_hold: assert property (
    (cs || idle) && ctrl.burst_step_n && hi |=> $stable(dq_out)) else $error("moved");
  a_rst_quiet: assert property (disable iff (1'b0) !arst_n |-> dq_oe == 18'h0) else $error("rst");
endmodule
bind bcs_sram bcs_sram_props bcs_sram_props_i (.clk_sys(clk_sys), .arst_n(arst_n), .ctrl(ctrl),
  .out_enable_n(out_enable_n), .dq_out(dq_out), .dq_oe(dq_oe));

// File: bench/bcs_host_model.sv
// Host side of the shared data and parity bus
module bcs_host_model (
  input  wire logic        drive,
  input  wire logic [17:0] host_d,
  input  wire logic [17:0] dq_out,
  input  wire logic [17:0] dq_oe,
  output logic      [17:0] bus,
  output logic             clash
);
  // Released bits show the inverse of the host data
  assign bus = drive ? host_d : (dq_out & dq_oe) | (~host_d & ~dq_oe);
  // Host drives only onto a floated bus
  assign clash = drive && (dq_oe != 18'h0);
endmodule

// File: bench/tb_bcs_sram.sv
// Random bench for the burst cache RAM
module tb_bcs_sram;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0, arst_n = 1'h1, oe_n = 1'h1, drv = 1'h0, clash;
  logic [5:0] c = 6'h3f;
  logic [1:0] k;
  logic [15:0] a = 16'h0, b;
  logic [17:0] hd = 18'h0, d, bus, q, oe, q2, oe2, m [logic [15:0]];
  int n_errors = 0, check_count = 0, cyc = 0;
`define CHK(x, y) begin check_count++; if ((x) !== (y)) begin n_errors++; \
  $display("[ERR] %0t got %h want %h", $time, x, y); end end
  bcs_sram bcs_sram_i (.clk_sys(clk_sys), .arst_n(arst_n), .ctrl(c), .out_enable_n(oe_n),
    .addr(a), .dq_in(bus), .dq_out(q), .dq_oe(oe));
  bcs_sram #(.ORDER(bcs_pkg::BCS_LINEAR)) bcs_sram_lin_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .ctrl(c), .out_enable_n(oe_n), .addr(a), .dq_in(bus), .dq_out(q2), .dq_oe(oe2));
  bcs_host_model bcs_host_model_i (.drive(drv), .host_d(hd), .dq_out(q), .dq_oe(oe),
    .bus(bus), .clash(clash));
  // Clock and hang guard
  initial forever #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (++cyc > 2000) begin n_errors++; complete_run(); end
  // One cycle of control; host drives and drops output enable when either lane write is low
  task op(input logic [5:0] cc, input logic [15:0] aa, input logic [17:0] dd);
    c = cc;
    a = aa;
    hd = dd;
    drv = !(cc[1] & cc[0]);
    oe_n = drv;
    @(posedge clk_sys);
    #1;
  endtask
  // Shadow memory lane update
  task upd(input logic [15:0] aa, input logic [17:0] dd, input logic [1:0] kk);
    if (!kk[0]) m[aa][8:0] = dd[8:0];
    if (!kk[1]) m[aa][17:9] = dd[17:9];
  endtask
  // Strobed read and compare
  task rd(input logic [5:0] cc, input logic [15:0] aa);
    op(cc, aa, 18'h0);
    `CHK(q, m[aa])
    `CHK(q2, m[aa])
    `CHK(oe, 18'h3ffff)
  endtask
  task complete_run();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Reset, random lane writes, then bursts checked in both interleaved and linear order
  initial begin
    void'($urandom(52));
    arst_n = 1'h0;
    repeat (10) @(posedge clk_sys);
    #1 arst_n = 1'h1;
    for (int i = 0; i < 40; i++) begin
      b = 16'($urandom);
      d = 18'($urandom);
      k = 2'($urandom_range(0, 2));
      op(6'h14, b, d);
      upd(b, d, 2'h0);
      op(6'h24, b, ~d);
      op(i[0] ? 6'h04 : 6'h0c, b, ~d);
      d = 18'($urandom);
      op(6'h1c | {4'h0, k}, b, d);
      upd(b, d, k);
      `CHK(clash, 1'b0)
      rd(i[1] ? 6'h0f : 6'h17, b);
    end
    $display("test lane_writes done");
    // Mid-run reset: outputs quiet, memory kept
    arst_n = 1'h0;
    @(posedge clk_sys);
    #1 `CHK(oe | q | oe2 | q2, 18'h0)
    arst_n = 1'h1;
    for (int s = 0; s < 4; s++) begin
      b = 16'($urandom) & 16'hfffc | 16'(s);
      for (int j = 0; j < 4; j++) begin
        d = 18'($urandom);
        op(6'h14, b ^ 16'(j), d);
        upd(b ^ 16'(j), d, 2'h0);
      end
      rd(6'h0f, b);
      for (int j = 1; j < 4; j++) begin
        op(6'h1b, b, 18'h0);
        `CHK(q, m[b ^ 16'(j)])
        `CHK(q2, m[{b[15:2], 2'(b[1:0] + 2'(j))}])
        op(6'h1f, b, 18'h0);
        `CHK(q, m[b ^ 16'(j)])
        `CHK(q2, m[{b[15:2], 2'(b[1:0] + 2'(j))}])
      end
    end
    $display("test bursts done");
    complete_run();
  end
endmodule
